// ==== rtl/fct_bank.sv ====
// congestion threshold bank: command port, broadcast walker, link profiles, comparator
// assumes commands are held stable only in the cycle CMD_VALID and CMD_READY are high
`timescale 1ns/1ps
`default_nettype none
module fct_bank
    import fct_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic COMBINED_MODE,
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire logic [4:0] CMD_TYPE,
    input wire logic CMD_PROFILE,
    input wire fct_index_s CMD_INDEX,
    input wire fct_flags_s CMD_FLAGS,
    input wire logic [VAL_W-1:0] CMD_VALUE,
    output logic CMD_READY,
    output logic RSP_VALID,
    output logic RSP_ERR,
    output logic [VAL_W-1:0] RSP_VALUE,
    input wire logic LINK_SET_VALID,
    input wire logic [NUM_LINKS-1:0] LINK_SET_MASK,
    input wire logic LINK_SET_PROFILE,
    input wire logic LINK_GET_PROFILE,
    output logic [NUM_LINKS-1:0] LINK_PROFILE,
    output logic [NUM_LINKS-1:0] LINK_LIST,
    output logic [CNT_W-1:0] LINK_COUNT,
    input wire logic CMP_VALID,
    input wire logic [4:0] CMP_TYPE,
    input wire logic [LINK_W-1:0] CMP_LINK,
    input wire logic CMP_THIRD_STAGE,
    input wire logic CMP_LOCAL_ROUTE,
    input wire logic [3:0] CMP_SLOT,
    input wire logic [VAL_W-1:0] CMP_OCC,
    output logic CELL_DROP,
    output logic LINK_FC
);
    // ****************************************************************
    // command state machine
    // ****************************************************************
    typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_WALK = 3'b010, ST_READ = 3'b100} fct_state_e;

    fct_state_e st_q, st_d;
    logic [WALK_W-1:0] walk_q, walk_d;
    logic [4:0] ty_q, ty_d;
    logic prof_q, prof_d;
    fct_index_s idx_q, idx_d;
    fct_flags_s flg_q, flg_d;
    logic [VAL_W-1:0] val_q, val_d;
    logic derived_q, derived_d;
    logic [ADDR_W-1:0] raddr_q, raddr_d;
    logic rsp_valid_q, rsp_valid_d;
    logic rsp_err_q, rsp_err_d;
    logic [VAL_W-1:0] rsp_value_q, rsp_value_d;
    logic [VAL_W-1:0] mid_q [8];
    logic [VAL_W-1:0] mid_d [8];
    fct_attr_s cattr, wattr;
    logic wr_ok, slot_hit, grp_ok, lr_ok, mem_we;
    logic [ADDR_W-1:0] waddr;
    logic [VAL_W-1:0] rd_a, rd_b;
    logic rd_grp, rd_lr, rd_prof;
    logic [2:0] mid_base;

    assign cattr = fct_attr(CMD_TYPE);
    assign wattr = fct_attr(ty_q);
    // walk slot layout: walk[5] local copy, walk[4] third-stage group, walk[3:0] class slot
    assign slot_hit = fct_match(wattr, idx_q, walk_q[3:0]);
    // third-stage group exists only in combined mode no flag means both
    assign grp_ok = walk_q[4] ? (COMBINED_MODE && !flg_q.first_only) : !flg_q.third_only;
    // local copy only on types that have one; no flag means non-local
    assign lr_ok = walk_q[5] ? (wattr.has_lr && flg_q.lr_only) : !flg_q.lr_only;
    assign mem_we = (st_q == ST_WALK) && slot_hit && grp_ok && lr_ok &&
                    !(ty_q == TY_MID_FIFO_SIZE_PIPE && walk_q[1:0] == MID_DERIVED_PIPE);
    assign waddr = {ty_q, walk_q[5], walk_q[4], prof_q, walk_q[3:0]};
    // size values off a multiple of four are refused; disabled value is exempt
    assign wr_ok = !fct_bad_index(cattr, CMD_INDEX) && cattr.valid &&
                   !(cattr.kind == KD_SIZE && CMD_VALUE[1:0] != 2'h0 && CMD_VALUE != TH_DISABLED);
    // profile-less types live at profile zero only
    assign rd_prof = cattr.has_prof ? CMD_PROFILE : 1'b0;
    assign rd_grp = COMBINED_MODE && CMD_FLAGS.third_only;
    assign rd_lr = cattr.has_lr && CMD_FLAGS.lr_only;
    assign mid_base = {rd_grp, rd_prof, 1'b0};

    // next-state: accept, walk every slot for each write, answer reads
    always_comb begin
        st_d = st_q;
        walk_d = walk_q;
        ty_d = ty_q;
        prof_d = prof_q;
        idx_d = idx_q;
        flg_d = flg_q;
        val_d = val_q;
        derived_d = 1'b0;
        raddr_d = raddr_q;
        rsp_valid_d = 1'b0;
        rsp_err_d = 1'b0;
        rsp_value_d = rsp_value_q;
        for (int i = 0; i < 8; i++) begin
            mid_d[i] = mid_q[i];
        end
        case (st_q)
            ST_IDLE: begin
                if (CMD_VALID && CMD_WRITE) begin
                    if (wr_ok && !(!cattr.has_prof && CMD_PROFILE)) begin
                        st_d = ST_WALK;
                        walk_d = '0;
                        ty_d = CMD_TYPE;
                        prof_d = CMD_PROFILE;
                        idx_d = CMD_INDEX;
                        flg_d = CMD_FLAGS;
                        val_d = CMD_VALUE; // all-ones stored as is, means disabled
                    end else begin
                        rsp_valid_d = 1'b1;
                        rsp_err_d = 1'b1;
                    end
                end else if (CMD_VALID) begin
                    if (!cattr.valid || fct_bad_index(cattr, CMD_INDEX) || fct_any_all(cattr, CMD_INDEX)) begin
                        rsp_valid_d = 1'b1;
                        rsp_err_d = 1'b1;
                    end else begin
                        st_d = ST_READ;
                        raddr_d = {CMD_TYPE, rd_lr, rd_grp, rd_prof, fct_slot(cattr, CMD_INDEX)};
                        derived_d = (CMD_TYPE == TY_MID_FIFO_SIZE_PIPE) &&
                                    (CMD_INDEX.pipe == MID_DERIVED_PIPE);
                        // derived pipe 2 share: pool minus the two written pipes
                        rsp_value_d = 16'(MID_FIFO_TOTAL - mid_q[mid_base] - mid_q[mid_base + 3'h1]);
                    end
                end
            end
            ST_WALK: begin
                if (mem_we && ty_q == TY_MID_FIFO_SIZE_PIPE && walk_q[1] == 1'b0) begin
                    mid_d[{walk_q[4], prof_q, walk_q[0]}] = val_q;
                end
                walk_d = 6'(walk_q + 6'h01);
                if (walk_q == WALK_LAST) begin
                    st_d = ST_IDLE;
                    rsp_valid_d = 1'b1;
                end
            end
            ST_READ: begin
                st_d = ST_IDLE;
                rsp_valid_d = 1'b1;
                if (!derived_q) begin
                    rsp_value_d = rd_a;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // registers of the command path
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_q <= ST_IDLE;
            walk_q <= '0;
            ty_q <= 5'h00;
            prof_q <= 1'b0;
            idx_q <= '0;
            flg_q <= '0;
            val_q <= RST_VAL;
            derived_q <= 1'b0;
            raddr_q <= '0;
            rsp_valid_q <= 1'b0;
            rsp_err_q <= 1'b0;
            rsp_value_q <= RST_VAL;
            for (int i = 0; i < 8; i++) begin
                mid_q[i] <= RST_VAL;
            end
        end else begin
            st_q <= st_d;
            walk_q <= walk_d;
            ty_q <= ty_d;
            prof_q <= prof_d;
            idx_q <= idx_d;
            flg_q <= flg_d;
            val_q <= val_d;
            derived_q <= derived_d;
            raddr_q <= raddr_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_err_q <= rsp_err_d;
            rsp_value_q <= rsp_value_d;
            for (int i = 0; i < 8; i++) begin
                mid_q[i] <= mid_d[i];
            end
        end
    end

    assign RSP_VALID = rsp_valid_q;
    assign RSP_ERR = rsp_err_q;
    assign RSP_VALUE = rsp_value_q;
    assign CMD_READY = st_q[0]; // one-hot idle bit, straight from its flop

    // ****************************************************************
    // link profile selectors
    // ****************************************************************
    logic [NUM_LINKS-1:0] lsel_q, lsel_d, list_q, list_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;

    // selector per link, list and count of the asked profile
    always_comb begin
        lsel_d = lsel_q;
        if (LINK_SET_VALID) begin
            lsel_d = (lsel_q & ~LINK_SET_MASK) | (LINK_SET_PROFILE ? LINK_SET_MASK : '0);
        end
        list_d = LINK_GET_PROFILE ? lsel_q : ~lsel_q;
        cnt_d = '0;
        for (int i = 0; i < NUM_LINKS; i++) begin
            cnt_d = 5'(cnt_d + {4'h0, list_d[i]});
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            lsel_q <= '0;
            list_q <= '0;
            cnt_q <= '0;
        end else begin
            lsel_q <= lsel_d;
            list_q <= list_d;
            cnt_q <= cnt_d;
        end
    end

    assign LINK_PROFILE = lsel_q;
    assign LINK_LIST = list_q;
    assign LINK_COUNT = cnt_q;

    // ****************************************************************
    // occupancy comparator
    // ****************************************************************
    fct_attr_s pattr;
    logic [ADDR_W-1:0] caddr;
    logic cmp_p_q, cmp_p_d;
    fct_kind_e kind_q, kind_d;
    logic [VAL_W-1:0] occ_q, occ_d;
    logic drop_q, drop_d, fc_q, fc_d, hit;

    assign pattr = fct_attr(CMP_TYPE);
    // profile comes from the link's selector; profile-less types sit at profile zero
    assign caddr = {CMP_TYPE, CMP_LOCAL_ROUTE && pattr.has_lr, CMP_THIRD_STAGE && COMBINED_MODE,
                    pattr.has_prof && lsel_q[CMP_LINK], CMP_SLOT};
    // disabled thresholds never act; reaching the level does
    assign hit = cmp_p_q && (rd_b != TH_DISABLED) && (occ_q >= rd_b);

    // one-cycle lookup, then registered drop or flow-control pulse
    always_comb begin
        cmp_p_d = CMP_VALID && pattr.valid;
        kind_d = pattr.kind;
        occ_d = CMP_OCC;
        drop_d = hit && (kind_q == KD_DROP);
        fc_d = hit && (kind_q == KD_FC);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cmp_p_q <= 1'b0;
            kind_q <= KD_NONE;
            occ_q <= RST_VAL;
            drop_q <= 1'b0;
            fc_q <= 1'b0;
        end else begin
            cmp_p_q <= cmp_p_d;
            kind_q <= kind_d;
            occ_q <= occ_d;
            drop_q <= drop_d;
            fc_q <= fc_d;
        end
    end

    assign CELL_DROP = drop_q;
    assign LINK_FC = fc_q;

    // ****************************************************************
    // storage
    // ****************************************************************
    fct_mem u_mem (
        .clk(CLK),
        .rst(RST),
        .we(mem_we),
        .waddr(waddr),
        .wdata(val_q),
        .raddr_a(raddr_d), // address presented at the take edge so data is ready in the read state
        .rdata_a(rd_a),
        .raddr_b(caddr),
        .rdata_b(rd_b)
    );
endmodule : fct_bank
`default_nettype wire

// ==== rtl/fct_pkg.sv ====
// constants, types and decode functions for the congestion threshold bank
// assumes one 50 MHz core clock and a software command port with no bus
//
// Functional notes
// - two threshold profiles, 0 and 1, for link groups with different limits
// - combined edge mode keeps separate profile pairs for first- and third-stage links
// - pipe index takes 0 to 2; all-select writes every pipe
// - priority index takes 0 to 3; all-select writes every priority
// - pipe-level index takes level 0 to 2 with pipe; all-select per field
// - cast-priority index is unicast, multicast or both, with priority 0 to 3
// - local-route and non-local-route copies; no flag means non-local only
// - only transmit tag drop, fragment drop and fifo size have local copies
// - write may target first- or third-stage links; no flag updates both
// - every threshold belongs to one stage and one indexing scheme
// - value all-ones disables the threshold so it never acts
// - middle fifo size of pipe 2 is not writable and is derived
// - per-pipe per-profile flow-control generation for receive and bypass transmit
// - read by profile, index, type and flags returns the stored value
// - each link has profile selector; readback gives count and list per profile
package fct_pkg;
    // ****************************************************************
    // sizes and fixed values
    // ****************************************************************
    localparam int NUM_LINKS = 16;
    localparam int LINK_W = 4;
    localparam int CNT_W = 5;
    localparam int VAL_W = 16;
    localparam int ADDR_W = 12;
    localparam int DEPTH = 4096;
    localparam int WALK_W = 6;
    localparam logic [5:0] WALK_LAST = 6'h3F;
    localparam logic [15:0] TH_DISABLED = 16'hFFFF;
    localparam logic [15:0] MID_FIFO_TOTAL = 16'h0300; // plain default pool size
    localparam logic [1:0] PIPE_LAST = 2'h2;
    localparam logic [1:0] LEVEL_LAST = 2'h2;
    localparam logic [1:0] MID_DERIVED_PIPE = 2'h2;
    localparam logic [1:0] CAST_UC = 2'h0;
    localparam logic [1:0] CAST_MC = 2'h1;
    localparam logic [1:0] CAST_ALL = 2'h2;
    localparam logic [15:0] RST_VAL = 16'h0000;

    // ****************************************************************
    // threshold types, schemes, stages, kinds
    // ****************************************************************
    typedef enum logic [4:0] {
        TY_MID_TAG_DROP_CLASS = 5'h00, TY_TX_LINK_LOAD_DROP_PIPE = 5'h01,
        TY_TX_FRAG_GUAR_PIPE = 5'h02, TY_SHR_DROP_CLASS = 5'h03,
        TY_SHR_MC_COPIES_DROP_PRIO = 5'h04, TY_MID_FRAG_DROP_CLASS = 5'h05,
        TY_SHR_BANK_MC_DROP_PRIO = 5'h06, TY_TX_TAG_DROP_CLASS = 5'h07,
        TY_TX_FRAG_DROP_CLASS = 5'h08, TY_RX_FRAG_DROP_PIPE = 5'h09,
        TY_MID_MC_COPIES_FC_PRIO = 5'h0A, TY_RX_MC_LOW_DROP_PIPE = 5'h0B,
        TY_RX_FC_PIPE = 5'h0C, TY_TX_BYPASS_FC_PIPE = 5'h0D,
        TY_TX_FIFO_SIZE_PIPE = 5'h0E, TY_MID_FIFO_SIZE_PIPE = 5'h0F,
        TY_RX_FIFO_SIZE_PIPE = 5'h10
    } fct_type_e;
    typedef enum logic [1:0] {SC_PIPE = 2'h0, SC_PRIO = 2'h1, SC_PIPE_LEVEL = 2'h2, SC_CAST_PRIO = 2'h3} fct_scheme_e;
    typedef enum logic [1:0] {SG_RECEIVE = 2'h0, SG_MIDDLE = 2'h1, SG_TRANSMIT = 2'h2, SG_SHARED = 2'h3} fct_stage_e;
    typedef enum logic [1:0] {KD_DROP = 2'h0, KD_FC = 2'h1, KD_SIZE = 2'h2, KD_NONE = 2'h3} fct_kind_e;

    typedef struct packed {
        logic valid;
        fct_scheme_e scheme;
        fct_stage_e stage;
        logic has_prof;
        logic has_lr;
        fct_kind_e kind;
    } fct_attr_s;

    typedef struct packed {
        logic pipe_all;
        logic [1:0] pipe;
        logic level_all;
        logic [1:0] level;
        logic prio_all;
        logic [1:0] prio;
        logic [1:0] cast;
    } fct_index_s;

    typedef struct packed {
        logic lr_only;
        logic nlr_only;
        logic first_only;
        logic third_only;
    } fct_flags_s;

    // ****************************************************************
    // decode functions
    // ****************************************************************
    // one stage and one scheme per type lr copies
    function automatic fct_attr_s fct_attr(input logic [4:0] ty);
        fct_attr_s a;
        a = '{1'b1, SC_PIPE, SG_RECEIVE, 1'b1, 1'b0, KD_DROP};
        case (ty)
            5'h00: a = '{1'b1, SC_CAST_PRIO, SG_MIDDLE, 1'b1, 1'b0, KD_DROP};
            5'h01, 5'h02: a = '{1'b1, SC_PIPE, SG_TRANSMIT, 1'b1, 1'b0, KD_DROP};
            5'h03: a = '{1'b1, SC_CAST_PRIO, SG_SHARED, 1'b0, 1'b0, KD_DROP};
            5'h04: a = '{1'b1, SC_PRIO, SG_SHARED, 1'b1, 1'b0, KD_DROP};
            5'h05: a = '{1'b1, SC_CAST_PRIO, SG_MIDDLE, 1'b1, 1'b0, KD_DROP};
            5'h06: a = '{1'b1, SC_PRIO, SG_SHARED, 1'b0, 1'b0, KD_DROP};
            5'h07, 5'h08: a = '{1'b1, SC_CAST_PRIO, SG_TRANSMIT, 1'b1, 1'b1, KD_DROP};
            5'h09, 5'h0B: a = '{1'b1, SC_PIPE, SG_RECEIVE, 1'b0, 1'b0, KD_DROP};
            5'h0A: a = '{1'b1, SC_PRIO, SG_MIDDLE, 1'b0, 1'b0, KD_FC};
            5'h0C: a = '{1'b1, SC_PIPE, SG_RECEIVE, 1'b1, 1'b0, KD_FC};
            5'h0D: a = '{1'b1, SC_PIPE, SG_TRANSMIT, 1'b1, 1'b0, KD_FC};
            5'h0E: a = '{1'b1, SC_PIPE, SG_TRANSMIT, 1'b1, 1'b1, KD_SIZE};
            5'h0F: a = '{1'b1, SC_PIPE, SG_MIDDLE, 1'b1, 1'b0, KD_SIZE};
            5'h10: a = '{1'b1, SC_PIPE, SG_RECEIVE, 1'b1, 1'b0, KD_SIZE};
            default: a = '{1'b0, SC_PIPE, SG_RECEIVE, 1'b0, 1'b0, KD_NONE};
        endcase
        return a;
    endfunction : fct_attr

    // index fields out of range for the type's scheme
    function automatic logic fct_bad_index(input fct_attr_s a, input fct_index_s x);
        logic bad;
        bad = 1'b0;
        case (a.scheme)
            SC_PIPE: bad = !x.pipe_all && (x.pipe > PIPE_LAST);
            SC_PRIO: bad = 1'b0;
            SC_PIPE_LEVEL: bad = (!x.pipe_all && (x.pipe > PIPE_LAST)) ||
                                 (!x.level_all && (x.level > LEVEL_LAST));
            SC_CAST_PRIO: bad = (x.cast > CAST_ALL);
            default: bad = 1'b1;
        endcase
        return bad;
    endfunction : fct_bad_index

    // does the stored slot w belong to the selection x
    function automatic logic fct_match(input fct_attr_s a, input fct_index_s x, input logic [3:0] w);
        logic m;
        m = 1'b0;
        case (a.scheme)
            SC_PIPE: m = (w[3:2] == 2'h0) && (w[1:0] <= PIPE_LAST) && (x.pipe_all || w[1:0] == x.pipe);
            SC_PRIO: m = (w[3:2] == 2'h0) && (x.prio_all || w[1:0] == x.prio);
            SC_PIPE_LEVEL: m = (w[3:2] <= PIPE_LAST) && (w[1:0] <= LEVEL_LAST) &&
                               (x.pipe_all || w[3:2] == x.pipe) && (x.level_all || w[1:0] == x.level);
            SC_CAST_PRIO: m = (w[3] == 1'b0) && (x.cast == CAST_ALL || {1'b0, w[2]} == x.cast) &&
                              (x.prio_all || w[1:0] == x.prio);
            default: m = 1'b0;
        endcase
        return m;
    endfunction : fct_match

    // slot of a single (non all-select) index
    function automatic logic [3:0] fct_slot(input fct_attr_s a, input fct_index_s x);
        logic [3:0] s;
        s = 4'h0;
        case (a.scheme)
            SC_PIPE: s = {2'h0, x.pipe};
            SC_PRIO: s = {2'h0, x.prio};
            SC_PIPE_LEVEL: s = {x.pipe, x.level};
            SC_CAST_PRIO: s = {1'b0, x.cast[0], x.prio};
            default: s = 4'h0;
        endcase
        return s;
    endfunction : fct_slot

    function automatic logic fct_any_all(input fct_attr_s a, input fct_index_s x);
        logic r;
        r = 1'b0;
        case (a.scheme)
            SC_PIPE: r = x.pipe_all;
            SC_PRIO: r = x.prio_all;
            SC_PIPE_LEVEL: r = x.pipe_all || x.level_all;
            SC_CAST_PRIO: r = x.prio_all || (x.cast == CAST_ALL);
            default: r = 1'b0;
        endcase
        return r;
    endfunction : fct_any_all
endpackage : fct_pkg

// ==== rtl/fct_mem.sv ====
// threshold storage: one write port, two registered read ports
// assumes the owner never writes and reads one address in the same cycle
`timescale 1ns/1ps
`default_nettype none
module fct_mem
    import fct_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [ADDR_W-1:0] waddr,
    input wire logic [VAL_W-1:0] wdata,
    input wire logic [ADDR_W-1:0] raddr_a,
    output logic [VAL_W-1:0] rdata_a,
    input wire logic [ADDR_W-1:0] raddr_b,
    output logic [VAL_W-1:0] rdata_b
);
    logic [VAL_W-1:0] mem [DEPTH];

    // power-up contents are disabled thresholds; reset does not clear them
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = TH_DISABLED;
        end
    end

    // storage array has no reset, so it maps onto block memory
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read data come out of registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_a <= RST_VAL;
            rdata_b <= RST_VAL;
        end else begin
            rdata_a <= mem[raddr_a];
            rdata_b <= mem[raddr_b];
        end
    end
endmodule : fct_mem
`default_nettype wire

// ==== bench/fct_bank_chk.sv ====
// assertions on the command, link and compare ports of the threshold bank
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module fct_bank_chk
    import fct_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CMD_VALID,
    input wire logic CMD_READY,
    input wire logic RSP_VALID,
    input wire logic RSP_ERR,
    input wire logic LINK_SET_VALID,
    input wire logic [NUM_LINKS-1:0] LINK_SET_MASK,
    input wire logic LINK_SET_PROFILE,
    input wire logic LINK_GET_PROFILE,
    input wire logic [NUM_LINKS-1:0] LINK_PROFILE,
    input wire logic [NUM_LINKS-1:0] LINK_LIST,
    input wire logic [CNT_W-1:0] LINK_COUNT,
    input wire logic CMP_VALID,
    input wire logic CELL_DROP,
    input wire logic LINK_FC
);
    // one domain, so clock and reset are stated once
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_link_list: assert property (!$past(RST) |->
        LINK_LIST == ($past(LINK_GET_PROFILE) ? $past(LINK_PROFILE) : ~$past(LINK_PROFILE)))
        else $error("link list does not follow selectors");
    a_link_count: assert property (LINK_COUNT == CNT_W'($countones(LINK_LIST)))
        else $error("link count differs from list");
    a_link_set: assert property (LINK_SET_VALID |=> ((LINK_PROFILE & $past(LINK_SET_MASK)) ==
        ($past(LINK_SET_MASK) & {NUM_LINKS{$past(LINK_SET_PROFILE)}}))) else $error("link selector not set");
    a_link_hold: assert property (!LINK_SET_VALID |=> $stable(LINK_PROFILE))
        else $error("link selector changed without set");
    a_cmd_answer: assert property (CMD_VALID && CMD_READY |-> ##[1:65] RSP_VALID)
        else $error("command got no answer");
    a_err_valid: assert property (RSP_ERR |-> RSP_VALID) else $error("error flag without answer");
    a_ready_back: assert property ($rose(CMD_READY) |-> RSP_VALID) else $error("ready returned without answer");
    a_drop_cause: assert property (CELL_DROP |-> $past(CMP_VALID, 2)) else $error("drop without compare");
    a_fc_cause: assert property (LINK_FC |-> $past(CMP_VALID, 2)) else $error("flow control without compare");
endmodule : fct_bank_chk
bind fct_bank fct_bank_chk u_chk (.CLK(CLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
    .RSP_VALID(RSP_VALID), .RSP_ERR(RSP_ERR), .LINK_SET_VALID(LINK_SET_VALID), .LINK_SET_MASK(LINK_SET_MASK),
    .LINK_SET_PROFILE(LINK_SET_PROFILE), .LINK_GET_PROFILE(LINK_GET_PROFILE), .LINK_PROFILE(LINK_PROFILE),
    .LINK_LIST(LINK_LIST), .LINK_COUNT(LINK_COUNT), .CMP_VALID(CMP_VALID), .CELL_DROP(CELL_DROP), .LINK_FC(LINK_FC));
`default_nettype wire

// ==== bench/test_fct_bank.sv ====
// self-checking bench for the threshold bank
// assumes the bank stands alone; the bench drives every port 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module test_fct_bank;
    import fct_pkg::*;
    logic clk = 1'h0, rst = 1'h1, cv = 1'h0, cw = 1'h0, cp = 1'h0, rdy, rv, re, ls = 1'h0, lsp = 1'h0, lg = 1'h0, cm = 1'h1;
    logic mv = 1'h0, drop, fc;
    logic [4:0] ct = 5'h00, mt = 5'h0C, lcnt;
    logic [3:0] cf = 4'h0, ml = 4'h0;
    logic [15:0] cval = 16'h0000, rval, occ = 16'h0000, lmask = 16'h0000, lprof, llist;
    fct_index_s cx = '0;
    int errors = 0, samples_checked = 0, cyc = 0;
    fct_bank u_dut (.CLK(clk), .RST(rst), .COMBINED_MODE(cm), .CMD_VALID(cv), .CMD_WRITE(cw), .CMD_TYPE(ct),
        .CMD_PROFILE(cp), .CMD_INDEX(cx), .CMD_FLAGS(fct_flags_s'(cf)), .CMD_VALUE(cval), .CMD_READY(rdy),
        .RSP_VALID(rv), .RSP_ERR(re), .RSP_VALUE(rval), .LINK_SET_VALID(ls), .LINK_SET_MASK(lmask),
        .LINK_SET_PROFILE(lsp), .LINK_GET_PROFILE(lg), .LINK_PROFILE(lprof), .LINK_LIST(llist), .LINK_COUNT(lcnt),
        .CMP_VALID(mv), .CMP_TYPE(mt), .CMP_LINK(ml), .CMP_THIRD_STAGE(1'h0), .CMP_LOCAL_ROUTE(1'h0),
        .CMP_SLOT(4'h1), .CMP_OCC(occ), .CELL_DROP(drop), .LINK_FC(fc));
    always #10 clk = ~clk;
    // hang guard: the whole run needs well under 3000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors = errors + 1;
            print_verdict();
        end
    end
    task print_verdict();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    function automatic fct_index_s ix(input logic [1:0] p);
        return fct_index_s'({1'h0, p, 8'h00});
    endfunction : ix
    // ****************************************************************
    // command port: drive for one cycle, then wait for the answer pulse
    // ****************************************************************
    task cmd(input logic w, input logic [4:0] t, input logic p, input fct_index_s x, input logic [3:0] f,
             input logic [15:0] v);
        int k;
        @(posedge clk); #1;
        cv = 1'h1; cw = w; ct = t; cp = p; cx = x; cf = f; cval = v;
        @(posedge clk); #1;
        cv = 1'h0;
        for (k = 0; k < 100 && rv !== 1'h1; k++) begin
            @(posedge clk); #1;
        end
        chk("answer", 16'h0001, {15'h0, rv});
    endtask : cmd
    task wr(input logic [4:0] t, input logic p, input fct_index_s x, input logic [3:0] f, input logic [15:0] v,
            input logic e);
        cmd(1'h1, t, p, x, f, v);
        chk("write error", {15'h0, e}, {15'h0, re});
    endtask : wr
    task rd(input logic [4:0] t, input logic p, input fct_index_s x, input logic [3:0] f, input logic [15:0] e);
        cmd(1'h0, t, p, x, f, 16'h0000);
        chk("read value", e, rval);
    endtask : rd
    // compare a pipe-1 occupancy on one link; the pulse stands for the cycle after the edge that follows take
    task t_cmp(input logic [3:0] l, input logic [15:0] o, input logic e);
        @(posedge clk); #1;
        mv = 1'h1; ml = l; occ = o;
        @(posedge clk); #1;
        mv = 1'h0;
        @(posedge clk); #1;
        chk("flow control", {15'h0, e && mt == 5'h0C}, {15'h0, fc});
        chk("cell drop", {15'h0, e && mt != 5'h0C}, {15'h0, drop});
    endtask : t_cmp
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 1'h0;
        @(posedge clk); #1;
        chk("idle ready", 16'h0001, {15'h0, rdy});
        chk("link count", 16'h0010, {11'h0, lcnt});
        wr(5'h0C, 1'h1, ix(2'h1), 4'h0, 16'h0010, 1'h0);
        rd(5'h0C, 1'h1, ix(2'h1), 4'h0, 16'h0010);
        rd(5'h0C, 1'h0, ix(2'h1), 4'h0, 16'hFFFF);
        wr(5'h0D, 1'h0, fct_index_s'(11'h400), 4'h0, 16'h0020, 1'h0);
        for (int p = 0; p < 3; p++) rd(5'h0D, 1'h0, ix(2'(p)), 4'h0, 16'h0020);
        wr(5'h0C, 1'h0, ix(2'h3), 4'h0, 16'h0001, 1'h1);
        wr(5'h03, 1'h1, ix(2'h0), 4'h0, 16'h0001, 1'h1);
        wr(5'h10, 1'h0, ix(2'h0), 4'h0, 16'h0006, 1'h1);
        wr(5'h11, 1'h0, ix(2'h0), 4'h0, 16'h0001, 1'h1);
        wr(5'h04, 1'h0, fct_index_s'(11'h010), 4'h0, 16'h0050, 1'h0);
        rd(5'h04, 1'h0, fct_index_s'(11'h00C), 4'h0, 16'h0050);
        wr(5'h07, 1'h0, fct_index_s'(11'h00A), 4'h0, 16'h0060, 1'h0);
        rd(5'h07, 1'h0, fct_index_s'(11'h009), 4'h0, 16'h0060);
        rd(5'h07, 1'h0, fct_index_s'(11'h008), 4'h0, 16'h0060);
        rd(5'h0F, 1'h0, ix(2'h2), 4'h0, 16'h0300);
        wr(5'h0F, 1'h0, ix(2'h0), 4'h0, 16'h0100, 1'h0);
        wr(5'h0F, 1'h0, ix(2'h2), 4'h0, 16'h0040, 1'h0);
        rd(5'h0F, 1'h0, ix(2'h2), 4'h0, 16'h0200);
        wr(5'h0C, 1'h0, ix(2'h0), 4'h1, 16'h0030, 1'h0);
        rd(5'h0C, 1'h0, ix(2'h0), 4'h1, 16'h0030);
        rd(5'h0C, 1'h0, ix(2'h0), 4'h0, 16'hFFFF);
        wr(5'h0E, 1'h0, ix(2'h0), 4'h8, 16'h0040, 1'h0);
        rd(5'h0E, 1'h0, ix(2'h0), 4'h8, 16'h0040);
        rd(5'h0E, 1'h0, ix(2'h0), 4'h0, 16'hFFFF);
        // attach links 0..3 to profile 1 and list that profile
        @(posedge clk); #1;
        ls = 1'h1; lmask = 16'h000F; lsp = 1'h1; lg = 1'h1;
        @(posedge clk); #1;
        ls = 1'h0;
        @(posedge clk); #1;
        chk("link list", 16'h000F, llist);
        chk("link count", 16'h0004, {11'h0, lcnt});
        chk("link profile", 16'h000F, lprof);
        t_cmp(4'h0, 16'h0010, 1'h1);
        t_cmp(4'h0, 16'h000F, 1'h0);
        t_cmp(4'h4, 16'hFFFF, 1'h0);
        wr(5'h01, 1'h1, ix(2'h1), 4'h0, 16'h0010, 1'h0);
        mt = 5'h01;
        t_cmp(4'h0, 16'h0010, 1'h1);
        // without the combined mode a third-stage read falls back to the first-stage group
        cm = 1'h0;
        rd(5'h0C, 1'h0, ix(2'h0), 4'h1, 16'hFFFF);
        print_verdict();
    end
endmodule : test_fct_bank
`default_nettype wire
